// ### rtl/opcode_field_decoder.sv
// Operand field decoder with accumulator, bank, flag, product and table state
// Operation
// RULE_01: Access bit 0 selects the fixed access region; bank selector ignored.
// RULE_02: Access bit 1 takes the RAM bank from the bank selector register.
// RULE_03: Destination bit 0 writes the result to the accumulator only.
// RULE_04: Destination bit 1 writes the result back to the addressed file register.
// RULE_05: Bit operations use a three-bit position within an 8-bit register.
// RULE_06: File field is an 8-bit address or a 2-bit pointer designator.
// RULE_07: Register moves carry 12-bit source and 12-bit destination addresses.
// RULE_08: Fast bit 1 saves or restores shadows; 0 leaves shadows untouched.
// RULE_09: Table transfers apply none, post-increment, post-decrement or pre-increment.
// RULE_10: Table pointer is 21 bits; transfers go through an 8-bit latch.
// RULE_11: Relative branches use two's complement offsets; calls and jumps absolute addresses.
// RULE_12: Literals are 8, 12 or 20 bits depending on the instruction.
// RULE_13: Indexed accesses use separate 7-bit source and destination offsets.
// RULE_14: Don't care bits never change execution.
// RULE_15: Five status flags kept: carry, digit carry, zero, overflow, negative.
// RULE_16: Multiply places its product in a high and low byte pair.
// RULE_17: A lone second word, top nibble all ones, executes as no-operation.
// RULE_18: Fields are extracted in the same cycle the word is presented.
`timescale 1ns/1ps
module opcode_field_decoder #(
  parameter int unsigned PTR_W = opcode_field_pkg::PTR_W
) (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic [4:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic [15:0]          instr_word,
  input  wire logic                 instr_valid,
  input  opcode_field_pkg::fmt_t    instr_fmt,
  input  wire logic [7:0]           alu_result,
  input  wire logic                 result_valid,
  input  opcode_field_pkg::flags_t  alu_flags,
  input  wire logic [4:0]           alu_flag_mask,
  input  wire logic [7:0]           file_rd_data,
  input  wire logic [7:0]           tbl_rd_data,
  output opcode_field_pkg::fields_t fields,
  output logic      [11:0]          data_addr,
  output logic                      second_word,
  output logic                      file_wr_en,
  output logic      [11:0]          file_wr_addr,
  output logic      [7:0]           file_wr_data,
  output logic                      move_valid,
  output logic      [11:0]          move_src_addr,
  output logic      [11:0]          move_dst_addr,
  output logic                      jump_valid,
  output logic                      jump_is_call,
  output logic      [19:0]          jump_target,
  output logic                      ptr_load_valid,
  output logic      [1:0]           ptr_sel,
  output logic      [11:0]          ptr_literal,
  output logic                      index_valid,
  output logic      [6:0]           index_src_off,
  output logic      [6:0]           index_dst_off,
  output logic      [PTR_W-1:0]     tbl_addr,
  output logic                      tbl_wr_en,
  output logic      [7:0]           tbl_wr_data,
  output logic      [7:0]           working_accumulator,
  output logic      [3:0]           bank_selector_register,
  output opcode_field_pkg::flags_t  status_flags,
  output logic      [7:0]           product_high_byte,
  output logic      [7:0]           product_low_byte,
  output logic      [PTR_W-1:0]     table_pointer,
  output logic      [7:0]           table_latch
);

  // Sign extension of a relative branch offset, used for both branch widths
  function automatic logic [PTR_W-1:0] sext_offset(input logic [10:0] raw, input logic wide);
    logic [PTR_W-1:0] res;
    res = '0;
    if (wide) begin
      res = {{(PTR_W-11){raw[10]}}, raw};
    end else begin
      res = {{(PTR_W-8){raw[7]}}, raw[7:0]};
    end
    return res;
  endfunction

  opcode_field_pkg::pend_t  pend_q,  pend_d;
  opcode_field_pkg::flags_t flags_q, flags_d, sh_flags_q, sh_flags_d;
  logic [7:0]       accum_q, accum_d, sh_accum_q, sh_accum_d;
  logic [3:0]       bank_q, bank_d, sh_bank_q, sh_bank_d;
  logic [7:0]       prod_hi_q, prod_hi_d, prod_lo_q, prod_lo_d;
  logic [PTR_W-1:0] tptr_q, tptr_d, tstep_addr, tstep_next;
  logic [7:0]       tlat_q, tlat_d;
  logic [11:0]      hold_q, hold_d;
  logic             fwr_q, fwr_d, mv_q, mv_d, jmp_q, jmp_d, call_q, call_d;
  logic             pl_q, pl_d, ix_q, ix_d, twr_q, twr_d, ack_q, ack_d;
  logic [11:0]      fwa_q, fwa_d, msrc_q, msrc_d, mdst_q, mdst_d, plit_q, plit_d;
  logic [7:0]       fwd_q, fwd_d;
  logic [19:0]      jt_q, jt_d;
  logic [1:0]       psel_q, psel_d;
  logic [6:0]       zs_q, zs_d, zd_q, zd_d;
  logic [PTR_W-1:0] taddr_q, taddr_d;
  logic [31:0]      rdata_q, rdata_d;
  logic             exec, bus_wr, bus_rd;

  // RULE_18 same-cycle field extraction
  always_comb begin
    fields            = '0;
    fields.file_addr  = instr_word[7:0];
    fields.access_sel = instr_word[opcode_field_pkg::ACCESS_BIT];
    // RULE_05 bit position and mask
    fields.bit_pos    = instr_word[opcode_field_pkg::BIT_POS_LSB +: 3];
    fields.bit_mask   = 8'h01 << fields.bit_pos;
    fields.literal8   = instr_word[7:0];
    // RULE_11 relative offset
    fields.rel_offset = sext_offset(instr_word[10:0],
                                    instr_fmt == opcode_field_pkg::fmt_bra_rel11);
    fields.tbl_mode   = opcode_field_pkg::tbl_mode_t'(instr_word[1:0]);
    fields.tbl_write  = instr_word[opcode_field_pkg::TBL_WRITE_BIT];
    // RULE_14 fields outside the format are never looked at
    fields.dest_file  = (instr_fmt == opcode_field_pkg::fmt_byte) &
                        instr_word[opcode_field_pkg::DEST_BIT];
    fields.fast_sel   = (instr_fmt == opcode_field_pkg::fmt_return) ?
                        instr_word[opcode_field_pkg::RET_FAST_BIT] :
                        instr_word[opcode_field_pkg::CALL_FAST_BIT];
    // RULE_17 lone second word
    fields.nop        = (pend_q == opcode_field_pkg::pend_none) &
                        (instr_word[15:12] == opcode_field_pkg::SECOND_WORD_TAG);
  end

  // RULE_01 access region
  // RULE_02 banked address
  assign data_addr   = fields.access_sel ? {bank_q, fields.file_addr} :
                       {opcode_field_pkg::ACCESS_BANK, fields.file_addr};
  assign second_word = (pend_q != opcode_field_pkg::pend_none);
  assign exec        = instr_valid & ~fields.nop & ~second_word;

  table_pointer_step #(
    .PTR_W (PTR_W)
  ) u_tstep (
    .ptr         (tptr_q),
    .mode        (fields.tbl_mode),
    .access_addr (tstep_addr),
    .next_ptr    (tstep_next)
  );

  // Bus handshake: one wait cycle per access, then the answer
  assign ack_d           = (avs_read | avs_write) & ~ack_q;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign bus_wr          = avs_write & ack_q;
  assign bus_rd          = avs_read & ~ack_q;

  // Read data is captured in the wait cycle so it stands when waitrequest drops
  always_comb begin
    rdata_d = rdata_q;
    if (bus_rd) begin
      if (avs_address == opcode_field_pkg::REG_ACCUM) begin
        rdata_d = {24'h000000, accum_q};
      end else if (avs_address == opcode_field_pkg::REG_BANK) begin
        rdata_d = {28'h0000000, bank_q};
      end else if (avs_address == opcode_field_pkg::REG_FLAGS) begin
        rdata_d = {27'h0000000, flags_q};
      end else if (avs_address == opcode_field_pkg::REG_TPTR) begin
        rdata_d = {{(32-PTR_W){1'b0}}, tptr_q};
      end else if (avs_address == opcode_field_pkg::REG_TBLLAT) begin
        rdata_d = {24'h000000, tlat_q};
      end else if (avs_address == opcode_field_pkg::REG_PRODUCT) begin
        rdata_d = {16'h0000, prod_hi_q, prod_lo_q};
      end else if (avs_address == opcode_field_pkg::REG_STATE) begin
        rdata_d = {29'h00000000, pend_q};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
  end

  // Architectural state; core updates win over a bus write in the same cycle
  always_comb begin
    accum_d    = accum_q;
    bank_d     = bank_q;
    flags_d    = flags_q;
    tptr_d     = tptr_q;
    tlat_d     = tlat_q;
    prod_hi_d  = prod_hi_q;
    prod_lo_d  = prod_lo_q;
    sh_accum_d = sh_accum_q;
    sh_flags_d = sh_flags_q;
    sh_bank_d  = sh_bank_q;
    if (bus_wr & avs_byteenable[0]) begin
      if (avs_address == opcode_field_pkg::REG_ACCUM) begin
        accum_d = avs_writedata[7:0];
      end else if (avs_address == opcode_field_pkg::REG_BANK) begin
        bank_d = avs_writedata[3:0];
      end else if (avs_address == opcode_field_pkg::REG_FLAGS) begin
        flags_d = avs_writedata[4:0];
      end else if (avs_address == opcode_field_pkg::REG_TBLLAT) begin
        tlat_d = avs_writedata[7:0];
      end
    end
    if (bus_wr & (avs_address == opcode_field_pkg::REG_TPTR)) begin
      tptr_d[7:0]        = avs_byteenable[0] ? avs_writedata[7:0] : tptr_q[7:0];
      tptr_d[15:8]       = avs_byteenable[1] ? avs_writedata[15:8] : tptr_q[15:8];
      tptr_d[PTR_W-1:16] = avs_byteenable[2] ? avs_writedata[PTR_W-1:16] : tptr_q[PTR_W-1:16];
    end
    // RULE_03 result into accumulator
    if (exec & result_valid & ((instr_fmt == opcode_field_pkg::fmt_lit8) |
        ((instr_fmt == opcode_field_pkg::fmt_byte) & ~fields.dest_file))) begin
      accum_d = alu_result;
    end
    // RULE_15 flag update under mask
    if (exec & result_valid) begin
      flags_d = (flags_d & ~alu_flag_mask) | (alu_flags & alu_flag_mask);
    end
    // RULE_16 product pair
    if (exec & (instr_fmt == opcode_field_pkg::fmt_mult)) begin
      {prod_hi_d, prod_lo_d} = accum_q * file_rd_data;
    end
    // RULE_09 pointer update
    // RULE_10 latch transfer
    if (exec & (instr_fmt == opcode_field_pkg::fmt_table)) begin
      tptr_d = tstep_next;
      if (~fields.tbl_write) begin
        tlat_d = tbl_rd_data;
      end
    end
    // RULE_08 shadow save and restore
    if (exec & fields.fast_sel & (instr_fmt == opcode_field_pkg::fmt_call)) begin
      sh_accum_d = accum_q;
      sh_flags_d = flags_q;
      sh_bank_d  = bank_q;
    end
    if (exec & fields.fast_sel & (instr_fmt == opcode_field_pkg::fmt_return)) begin
      accum_d = sh_accum_q;
      flags_d = sh_flags_q;
      bank_d  = sh_bank_q;
    end
  end

  // Two-word sequencing and registered datapath controls
  always_comb begin
    pend_d  = pend_q;
    hold_d  = hold_q;
    fwr_d   = 1'b0;
    fwa_d   = fwa_q;
    fwd_d   = fwd_q;
    mv_d    = 1'b0;
    msrc_d  = msrc_q;
    mdst_d  = mdst_q;
    jmp_d   = 1'b0;
    call_d  = call_q;
    jt_d    = jt_q;
    pl_d    = 1'b0;
    psel_d  = psel_q;
    plit_d  = plit_q;
    ix_d    = 1'b0;
    zs_d    = zs_q;
    zd_d    = zd_q;
    twr_d   = 1'b0;
    taddr_d = taddr_q;
    // RULE_04 result back to file register
    if (exec & result_valid & ((instr_fmt == opcode_field_pkg::fmt_bit) |
        ((instr_fmt == opcode_field_pkg::fmt_byte) & fields.dest_file))) begin
      fwr_d = 1'b1;
      fwa_d = data_addr;
      fwd_d = alu_result;
    end
    if (exec & (instr_fmt == opcode_field_pkg::fmt_table)) begin
      taddr_d = tstep_addr;
      twr_d   = fields.tbl_write;
    end
    if (instr_valid) begin
      case (pend_q)
        opcode_field_pkg::pend_none: begin
          hold_d = instr_word[11:0];
          if (exec) begin
            case (instr_fmt)
              opcode_field_pkg::fmt_move:     pend_d = opcode_field_pkg::pend_move;
              opcode_field_pkg::fmt_goto:     pend_d = opcode_field_pkg::pend_goto;
              opcode_field_pkg::fmt_call:     pend_d = opcode_field_pkg::pend_call;
              opcode_field_pkg::fmt_ptr_load: pend_d = opcode_field_pkg::pend_ptr;
              opcode_field_pkg::fmt_indexed:  pend_d = opcode_field_pkg::pend_index;
              default:                        pend_d = opcode_field_pkg::pend_none;
            endcase
          end
        end
        // RULE_07 12-bit move addresses
        opcode_field_pkg::pend_move: begin
          mv_d   = 1'b1;
          msrc_d = hold_q;
          mdst_d = instr_word[11:0];
          pend_d = opcode_field_pkg::pend_none;
        end
        // RULE_12 20-bit literal
        opcode_field_pkg::pend_goto, opcode_field_pkg::pend_call: begin
          jmp_d  = 1'b1;
          call_d = (pend_q == opcode_field_pkg::pend_call);
          jt_d   = {instr_word[11:0], hold_q[7:0]};
          pend_d = opcode_field_pkg::pend_none;
        end
        // RULE_06 pointer designator
        opcode_field_pkg::pend_ptr: begin
          pl_d   = 1'b1;
          psel_d = hold_q[5:4];
          plit_d = {hold_q[3:0], instr_word[7:0]};
          pend_d = opcode_field_pkg::pend_none;
        end
        // RULE_13 source and destination offsets
        opcode_field_pkg::pend_index: begin
          ix_d   = 1'b1;
          zs_d   = hold_q[6:0];
          zd_d   = instr_word[6:0];
          pend_d = opcode_field_pkg::pend_none;
        end
        default: pend_d = opcode_field_pkg::pend_none;
      endcase
    end
  end

  // Register stage for all state groups
  always_ff @(posedge clk) begin
    if (!resetn) begin
      accum_q <= opcode_field_pkg::ACCUM_RST;
      bank_q <= opcode_field_pkg::BANK_RST;
      flags_q <= opcode_field_pkg::FLAGS_RST;
      tptr_q <= opcode_field_pkg::TPTR_RST;
      tlat_q <= opcode_field_pkg::TBLLAT_RST;
      prod_hi_q <= opcode_field_pkg::PROD_RST;
      prod_lo_q <= opcode_field_pkg::PROD_RST;
      sh_accum_q <= opcode_field_pkg::ACCUM_RST;
      sh_flags_q <= opcode_field_pkg::FLAGS_RST;
      sh_bank_q <= opcode_field_pkg::BANK_RST;
      pend_q <= opcode_field_pkg::pend_none;
      {hold_q, fwr_q, fwa_q, fwd_q, mv_q, msrc_q, mdst_q} <= '0;
      {jmp_q, call_q, jt_q, pl_q, psel_q, plit_q, ix_q, zs_q, zd_q} <= '0;
      {twr_q, taddr_q, ack_q, rdata_q} <= '0;
    end else begin
      accum_q <= accum_d;
      bank_q <= bank_d;
      flags_q <= flags_d;
      tptr_q <= tptr_d;
      tlat_q <= tlat_d;
      prod_hi_q <= prod_hi_d;
      prod_lo_q <= prod_lo_d;
      sh_accum_q <= sh_accum_d;
      sh_flags_q <= sh_flags_d;
      sh_bank_q <= sh_bank_d;
      pend_q <= pend_d;
      {hold_q, fwr_q, fwa_q, fwd_q, mv_q, msrc_q, mdst_q} <=
        {hold_d, fwr_d, fwa_d, fwd_d, mv_d, msrc_d, mdst_d};
      {jmp_q, call_q, jt_q, pl_q, psel_q, plit_q, ix_q, zs_q, zd_q} <=
        {jmp_d, call_d, jt_d, pl_d, psel_d, plit_d, ix_d, zs_d, zd_d};
      {twr_q, taddr_q, ack_q, rdata_q} <= {twr_d, taddr_d, ack_d, rdata_d};
    end
  end

  // Outputs straight from flip-flops
  assign avs_readdata           = rdata_q;
  assign file_wr_en             = fwr_q;
  assign file_wr_addr           = fwa_q;
  assign file_wr_data           = fwd_q;
  assign move_valid             = mv_q;
  assign move_src_addr          = msrc_q;
  assign move_dst_addr          = mdst_q;
  assign jump_valid             = jmp_q;
  assign jump_is_call           = call_q;
  assign jump_target            = jt_q;
  assign ptr_load_valid         = pl_q;
  assign ptr_sel                = psel_q;
  assign ptr_literal            = plit_q;
  assign index_valid            = ix_q;
  assign index_src_off          = zs_q;
  assign index_dst_off          = zd_q;
  assign tbl_addr               = taddr_q;
  assign tbl_wr_en              = twr_q;
  assign tbl_wr_data            = tlat_q;
  assign working_accumulator    = accum_q;
  assign bank_selector_register = bank_q;
  assign status_flags           = flags_q;
  assign product_high_byte      = prod_hi_q;
  assign product_low_byte       = prod_lo_q;
  assign table_pointer          = tptr_q;
  assign table_latch            = tlat_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_access_bank: assert property (!fields.access_sel |-> // RULE_01
    data_addr == {opcode_field_pkg::ACCESS_BANK, instr_word[7:0]}) else $error("access region");
  chk_bank_select: assert property (fields.access_sel |-> // RULE_02
    data_addr[11:8] == bank_selector_register) else $error("bank not from selector");
  chk_dest_accum: assert property (exec && result_valid && // RULE_03
    instr_fmt == opcode_field_pkg::fmt_byte && !instr_word[9] |=>
    working_accumulator == $past(alu_result) && !file_wr_en) else $error("accum dest");
  chk_dest_file: assert property (exec && result_valid && // RULE_04
    instr_fmt == opcode_field_pkg::fmt_byte && instr_word[9] |=>
    file_wr_en && file_wr_addr == $past(data_addr) && file_wr_data == $past(alu_result))
    else $error("file dest");
  chk_bit_mask: assert property (fields.bit_mask[instr_word[11:9]] && // RULE_05
    $onehot(fields.bit_mask)) else $error("bit mask");
  chk_move_pair: assert property (instr_valid && // RULE_07
    pend_q == opcode_field_pkg::pend_move |=>
    move_valid && move_dst_addr == $past(instr_word[11:0]) && move_src_addr == $past(hold_q))
    else $error("move addresses");
  chk_shadow_keep: assert property (exec && !fields.fast_sel && // RULE_08
    instr_fmt == opcode_field_pkg::fmt_call |=> $stable(sh_accum_q) && $stable(sh_bank_q))
    else $error("shadow touched");
  chk_table_post: assert property (exec && instr_fmt == opcode_field_pkg::fmt_table && // RULE_09
    fields.tbl_mode == opcode_field_pkg::tbl_post_inc |=>
    table_pointer == PTR_W'($past(table_pointer) + 1'b1) && tbl_addr == $past(table_pointer))
    else $error("post increment");
  chk_lone_nop: assert property (instr_valid && fields.nop && !avs_write |=> // RULE_17
    $stable(working_accumulator) && !file_wr_en && !jump_valid) else $error("lone second word");
  chk_product: assert property (exec && instr_fmt == opcode_field_pkg::fmt_mult |=> // RULE_16
    {product_high_byte, product_low_byte} == 16'($past(working_accumulator) * $past(file_rd_data)))
    else $error("product");

  cov_call_fast: cover property (exec && fields.fast_sel &&
    instr_fmt == opcode_field_pkg::fmt_call);
  cov_goto_pair: cover property (jump_valid && !jump_is_call);
  cov_pre_inc: cover property (exec && instr_fmt == opcode_field_pkg::fmt_table &&
    fields.tbl_mode == opcode_field_pkg::tbl_pre_inc);
  cov_bus_read: cover property (avs_read && !avs_waitrequest);

endmodule // opcode_field_decoder

// ### common/opcode_field_pkg.sv
// Shared constants, field positions, register map and carrier types for the field decoder
package opcode_field_pkg;

  // Instruction word layout
  localparam int unsigned WORD_W          = 16;
  localparam int unsigned FILE_ADDR_W     = 12;
  localparam int unsigned PTR_W           = 21;
  localparam int unsigned ACCESS_BIT      = 8;
  localparam int unsigned DEST_BIT        = 9;
  localparam int unsigned BIT_POS_LSB     = 9;
  localparam int unsigned CALL_FAST_BIT   = 8;
  localparam int unsigned RET_FAST_BIT    = 0;
  localparam int unsigned TBL_WRITE_BIT   = 2;
  localparam logic [3:0]  SECOND_WORD_TAG = 4'hf;
  localparam logic [3:0]  ACCESS_BANK     = 4'h0;

  // Register byte offsets on the bus
  localparam logic [4:0] REG_ACCUM   = 5'h00;
  localparam logic [4:0] REG_BANK    = 5'h04;
  localparam logic [4:0] REG_FLAGS   = 5'h08;
  localparam logic [4:0] REG_TPTR    = 5'h0c;
  localparam logic [4:0] REG_TBLLAT  = 5'h10;
  localparam logic [4:0] REG_PRODUCT = 5'h14;
  localparam logic [4:0] REG_STATE   = 5'h18;

  // Values after reset
  localparam logic [7:0]       ACCUM_RST  = 8'h00;
  localparam logic [3:0]       BANK_RST   = 4'h0;
  localparam logic [4:0]       FLAGS_RST  = 5'h00;
  localparam logic [PTR_W-1:0] TPTR_RST   = 21'h000000;
  localparam logic [7:0]       TBLLAT_RST = 8'h00;
  localparam logic [7:0]       PROD_RST   = 8'h00;

  // Operand layout class, given by the opcode decoder upstream
  typedef enum logic [3:0] {
    fmt_none, fmt_byte, fmt_bit, fmt_lit8, fmt_move, fmt_ptr_load, fmt_call, fmt_goto,
    fmt_bra_rel11, fmt_br_rel8, fmt_table, fmt_return, fmt_mult, fmt_indexed
  } fmt_t;

  // Table pointer update modes
  typedef enum logic [1:0] {tbl_none, tbl_post_inc, tbl_post_dec, tbl_pre_inc} tbl_mode_t;

  // Second-word expectation
  typedef enum logic [2:0] {pend_none, pend_move, pend_goto, pend_call, pend_ptr, pend_index}
    pend_t;

  typedef struct packed {
    logic negative;
    logic signed_wrap_flag;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } flags_t;

  typedef struct packed {
    logic [7:0]       file_addr;
    logic             access_sel;
    logic             dest_file;
    logic [2:0]       bit_pos;
    logic [7:0]       bit_mask;
    logic [7:0]       literal8;
    logic [PTR_W-1:0] rel_offset;
    logic             fast_sel;
    tbl_mode_t        tbl_mode;
    logic             tbl_write;
    logic             nop;
  } fields_t;

endpackage

// ### rtl/table_pointer_step.sv
// Table pointer access address and update for the four update modes
`timescale 1ns/1ps
module table_pointer_step #(
  parameter int unsigned PTR_W = 21
) (
  input  wire logic [PTR_W-1:0]             ptr,
  input  opcode_field_pkg::tbl_mode_t       mode,
  output logic      [PTR_W-1:0]             access_addr,
  output logic      [PTR_W-1:0]             next_ptr
);

  logic [PTR_W-1:0] ptr_inc;
  logic [PTR_W-1:0] ptr_dec;

  // Wraps at the top of program memory, as a plain counter does
  assign ptr_inc = ptr + 1'b1;
  assign ptr_dec = ptr - 1'b1;

  // RULE_09 mode select
  always_comb begin
    access_addr = ptr;
    next_ptr    = ptr;
    case (mode)
      opcode_field_pkg::tbl_post_inc: next_ptr = ptr_inc;
      opcode_field_pkg::tbl_post_dec: next_ptr = ptr_dec;
      opcode_field_pkg::tbl_pre_inc: begin
        access_addr = ptr_inc;
        next_ptr    = ptr_inc;
      end
      default: next_ptr = ptr;
    endcase
  end

endmodule // table_pointer_step

// ### verif/datapath_model.sv
// Far-side stand-in for the register file and program memory reads
`timescale 1ns/1ps
module datapath_model (
  input  wire logic [20:0] table_pointer,
  input  wire logic [11:0] data_addr,
  output logic      [7:0]  file_rd_data,
  output logic      [7:0]  tbl_rd_data
);
  // Contents follow the low address byte, so a wrong low byte shows up as wrong data
  assign file_rd_data = data_addr[7:0] ^ 8'h3c;
  assign tbl_rd_data = table_pointer[7:0] ^ 8'ha5; // Read at the pointer, not a pre-step
endmodule // datapath_model

// ### verif/opcode_field_decoder_bench.sv
// Self-checking bench for the operand field decoder
`timescale 1ns/1ps
module opcode_field_decoder_bench;
  logic        clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0]  avs_address = 5'h00, alu_flag_mask = 5'h1f;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0]  avs_byteenable = 4'hf, bank_selector_register;
  logic [15:0] instr_word = 16'h0000;
  logic        instr_valid = 1'b0, result_valid = 1'b0, avs_waitrequest, second_word;
  logic [7:0]  alu_result = 8'h77, file_rd_data, tbl_rd_data, file_wr_data, tbl_wr_data;
  opcode_field_pkg::flags_t  alu_flags = 5'h15, status_flags;
  opcode_field_pkg::fmt_t    instr_fmt = opcode_field_pkg::fmt_none;
  opcode_field_pkg::fields_t fields;
  logic [11:0] data_addr, file_wr_addr, move_src_addr, move_dst_addr, ptr_literal;
  logic        file_wr_en, move_valid, jump_valid, jump_is_call, ptr_load_valid;
  logic        index_valid, tbl_wr_en;
  logic [19:0] jump_target;
  logic [1:0]  ptr_sel;
  logic [6:0]  index_src_off, index_dst_off;
  logic [20:0] tbl_addr, table_pointer;
  logic [7:0]  working_accumulator, product_high_byte, product_low_byte, table_latch;
  int          n_errors = 0, checked = 0, cycles = 0;
  opcode_field_decoder DUT (.*);
  datapath_model far_end (.table_pointer(table_pointer), .data_addr(data_addr),
    .file_rd_data(file_rd_data), .tbl_rd_data(tbl_rd_data));
  always #25 clk = ~clk;
  // Cuts a hang short; the tests need under a hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("TB: %0d checks, %0d mismatches", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // One word for one cycle; ends where the registered answer stands
  task automatic exec(input opcode_field_pkg::fmt_t f, input logic [15:0] w, input logic rv);
    @(posedge clk);
    instr_fmt <= f;
    instr_word <= w;
    instr_valid <= 1'b1;
    result_valid <= rv;
    @(posedge clk);
    instr_valid <= 1'b0;
    result_valid <= 1'b0;
    @(negedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, opcode_field_pkg::REG_ACCUM, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 5'h1c, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, opcode_field_pkg::REG_BANK, 32'h5);
    bus(1'b0, opcode_field_pkg::REG_BANK, 32'h0);
    check(rd, 32'h5);
    $display("TB: register test done");
    exec(opcode_field_pkg::fmt_byte, 16'h2434, 1'b1);
    check(data_addr, 12'h034);
    check({file_wr_en, working_accumulator}, 9'h077);
    check(status_flags, 5'h15);
    exec(opcode_field_pkg::fmt_byte, 16'h2734, 1'b1);
    check(data_addr, 12'h534);
    check({file_wr_en, file_wr_addr, file_wr_data}, 21'h153477);
    exec(opcode_field_pkg::fmt_bit, 16'h9a12, 1'b0);
    check({fields.bit_pos, fields.bit_mask}, 11'h520);
    exec(opcode_field_pkg::fmt_move, 16'hc123, 1'b0);
    check(second_word, 1'b1);
    exec(opcode_field_pkg::fmt_none, 16'hf456, 1'b0);
    check({move_valid, move_src_addr, move_dst_addr}, 25'h1123456);
    @(posedge clk) alu_result <= 8'h11;
    exec(opcode_field_pkg::fmt_byte, 16'hf0ff, 1'b1);
    check({file_wr_en, working_accumulator}, 9'h077);
    exec(opcode_field_pkg::fmt_call, 16'he1ab, 1'b0);
    exec(opcode_field_pkg::fmt_none, 16'hf345, 1'b0);
    check({jump_valid, jump_is_call, jump_target}, 22'h3345ab);
    exec(opcode_field_pkg::fmt_lit8, 16'h0e00, 1'b1);
    check(working_accumulator, 8'h11);
    exec(opcode_field_pkg::fmt_return, 16'h0013, 1'b0);
    check(working_accumulator, 8'h77);
    exec(opcode_field_pkg::fmt_call, 16'he0cd, 1'b0);
    exec(opcode_field_pkg::fmt_none, 16'hf012, 1'b0);
    check({jump_valid, jump_is_call, jump_target}, 22'h3012cd);
    exec(opcode_field_pkg::fmt_goto, 16'hef01, 1'b0);
    exec(opcode_field_pkg::fmt_none, 16'hf0a0, 1'b0);
    check({jump_valid, jump_is_call, jump_target}, 22'h20a001);
    exec(opcode_field_pkg::fmt_ptr_load, 16'hee2a, 1'b0);
    exec(opcode_field_pkg::fmt_none, 16'hf0bc, 1'b0);
    check({ptr_load_valid, ptr_sel, ptr_literal}, 15'h6abc);
    exec(opcode_field_pkg::fmt_indexed, 16'he855, 1'b0);
    exec(opcode_field_pkg::fmt_none, 16'hf0aa, 1'b0);
    check({index_valid, index_src_off, index_dst_off}, 15'h6aaa);
    exec(opcode_field_pkg::fmt_br_rel8, 16'he3f0, 1'b0);
    check(fields.rel_offset, 21'h1ffff0);
    exec(opcode_field_pkg::fmt_mult, 16'h0212, 1'b0);
    check({product_high_byte, product_low_byte}, 16'h1562);
    $display("TB: field test done");
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, opcode_field_pkg::REG_TPTR, 32'h10);
      exec(opcode_field_pkg::fmt_table, {14'h0002, m[1:0]}, 1'b0);
      check(table_pointer, (m == 2) ? 21'h0f : (m == 0) ? 21'h10 : 21'h11);
      check(tbl_addr, (m == 3) ? 21'h11 : 21'h10);
      if (m == 0) check(table_latch, 8'hb5);
    end
    exec(opcode_field_pkg::fmt_table, 16'h0004, 1'b0);
    check({tbl_wr_en, tbl_wr_data}, 9'h1b5);
    $display("TB: table test done");
    print_verdict();
  end
endmodule // opcode_field_decoder_bench
